/* File: hw/wdt_host.sv */
// host end: turns register commands into i/o cycles on the watchdog port
`timescale 1ns/10ps
module wdt_host (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic [3:0] regAddr,
	input  wire logic [15:0] regWrData,
	input  wire logic regWr,
	input  wire logic regRd,
	output logic [15:0] regRdData,
	output logic intr,
	wdt_if.host       bus
);
	import wdt_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		host_state_type    phase;
		logic [7:0]        code;
		logic [EV_W-1:0]   status;
		logic [EV_W-1:0]   mask;
		logic [15:0]       rdData;
		logic              resetSeen1;
		logic              resetSeen2;
		logic              irqSeen1;
		logic              irqSeen2;
		logic              armed;
	} host_reg_type;

	host_reg_type state;
	host_reg_type next_state;
	logic [EV_W-1:0] events;

	always_comb begin
		next_state = state;
		events = '0;
		// device outputs come from another block: two flops first
		next_state.resetSeen1 = bus.cpuReset;
		next_state.resetSeen2 = state.resetSeen1;
		next_state.irqSeen1 = bus.cpuIrq;
		next_state.irqSeen2 = state.irqSeen1;
		events[EV_EXPIRE] = state.resetSeen2 | state.irqSeen2;
		next_state.rdData = 16'h0;
		case (state.phase)
			HOST_WRITE: begin
				next_state.phase = HOST_IDLE;
				next_state.armed = 1'b1;
				events[EV_DONE] = 1'b1;
			end
			HOST_READ: begin
				next_state.phase = HOST_IDLE;
				next_state.armed = 1'b0;
				events[EV_DONE] = 1'b1;
			end
			default: begin
				next_state.phase = HOST_IDLE;
			end
		endcase
		if (events[EV_EXPIRE]) begin
			next_state.armed = 1'b0;
		end
		if (regWr) begin
			if (regAddr == REG_CTRL) begin
				if (regWrData[CTRL_GO]) begin
					// only legal codes reach the port
					if (regWrData[7:0] >= CODE_MIN &&
						regWrData[7:0] <= CODE_MAX) begin
						next_state.code = regWrData[7:0];
						next_state.phase = HOST_WRITE;
					end else begin
						events[EV_REJECT] = 1'b1;
					end
				end else if (regWrData[CTRL_RD]) begin
					next_state.phase = HOST_READ;
				end
			end else if (regAddr == REG_MASK) begin
				next_state.mask = regWrData[EV_W-1:0];
			end
		end
		if (regRd) begin
			if (regAddr == REG_CTRL) begin
				next_state.rdData = {8'h00, state.code};
			end else if (regAddr == REG_STATUS) begin
				next_state.rdData = {13'h0, state.status};
			end else if (regAddr == REG_MASK) begin
				next_state.rdData = {13'h0, state.mask};
			end else if (regAddr == REG_DEVSTATE) begin
				next_state.rdData = {15'h0, state.armed};
			end else begin
				next_state.rdData = 16'h0;
			end
		end
		// read clears, but a fresh event wins
		if (regRd && regAddr == REG_STATUS) begin
			next_state.status = events;
		end else begin
			next_state.status = state.status | events;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign bus.ioAddr   = PORT_ADDR;
	assign bus.ioWrData = state.code;
	assign bus.ioWr     = (state.phase == HOST_WRITE);
	assign bus.ioRd     = (state.phase == HOST_READ);
	assign regRdData    = state.rdData;
	assign intr         = |(state.status & state.mask);
endmodule

/* File: shared/wdt_pkg.sv */
// package of constants and types shared by both ends of the watchdog link
package wdt_pkg;
	localparam int          CLK_HZ        = 125000000;
	localparam int          TICK_SEC      = 1;
	localparam int          TICK_CYCLES   = CLK_HZ * TICK_SEC;
	localparam logic [15:0] PORT_ADDR     = 16'h0443;
	localparam logic [7:0]  CODE_MIN      = 8'h01;
	localparam logic [7:0]  CODE_MAX      = 8'h3e;
	localparam logic [7:0]  DISABLED_READ = 8'h00;
	// host controller register offsets
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h1;
	localparam logic [3:0]  REG_MASK      = 4'h2;
	localparam logic [3:0]  REG_DEVSTATE  = 4'h3;
	// status and mask bit positions
	localparam int          EV_EXPIRE     = 0;
	localparam int          EV_REJECT     = 1;
	localparam int          EV_DONE       = 2;
	localparam int          EV_W          = 3;
	// control register fields
	localparam int          CTRL_GO       = 8;
	localparam int          CTRL_RD       = 9;
	typedef enum logic [1:0] {
		HOST_IDLE  = 2'b00,
		HOST_WRITE = 2'b01,
		HOST_READ  = 2'b10
	} host_state_type;
endpackage

/* File: shared/wdt_if.sv */
// interface joining the host's i/o cycles to the watchdog device
`timescale 1ns/10ps
interface wdt_if;
	logic [15:0] ioAddr;
	logic [7:0]  ioWrData;
	logic        ioWr;
	logic        ioRd;
	logic [7:0]  ioRdData;
	logic        cpuReset;
	logic        cpuIrq;
	modport device (
		input  ioAddr,
		input  ioWrData,
		input  ioWr,
		input  ioRd,
		output ioRdData,
		output cpuReset,
		output cpuIrq
	);
	modport host (
		output ioAddr,
		output ioWrData,
		output ioWr,
		output ioRd,
		input  ioRdData,
		input  cpuReset,
		input  cpuIrq
	);
endinterface

/* File: hw/wdt_device.sv */
// watchdog device: one i/o port, seconds countdown, reset or irq on expiry
`timescale 1ns/10ps
// Notes on behaviour
// - write to port 443h loads interval, starts
// - host writes only codes 01h through 3Eh
// - code counts whole seconds of timeout
// - each rewrite reloads countdown with new interval
// - read of the port disables the timer
// - expiry resets processor or raises interrupt
module wdt_device #(
	// clocks per second; a bench may shorten it to reach expiry
	parameter int TICK_LEN = wdt_pkg::TICK_CYCLES
) (
	input  wire logic sys_clk,
	input  wire logic rst_b,
	input  wire logic expireToIrq,
	wdt_if.device     bus,
	output logic      running
);
	import wdt_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic        enabled;
		logic [7:0]  seconds;
		logic [31:0] prescale;
		logic        modeIrq;
		logic        modeLatched;
		logic        resetOut;
		logic        irqOut;
		logic [7:0]  rdData;
	} dev_state_type;

	dev_state_type state;
	dev_state_type next_state;
	logic          hit;
	logic          secTick;

	always_comb begin
		next_state = state;
		hit = (bus.ioAddr == PORT_ADDR);
		secTick = (state.prescale == 32'(TICK_LEN - 1));
		// strap caught after reset release, never by the async reset
		if (!state.modeLatched) begin
			next_state.modeLatched = 1'b1;
			next_state.modeIrq = expireToIrq;
		end
		next_state.resetOut = 1'b0;
		next_state.irqOut = 1'b0;
		if (state.enabled) begin
			next_state.prescale = secTick ? 32'h0 : state.prescale + 32'h1;
			if (secTick) begin
				next_state.seconds = state.seconds - 8'h01;
				if (state.seconds == 8'h01) begin
					next_state.enabled = 1'b0;
					// one pulse, one kind only
					next_state.resetOut = !state.modeIrq;
					next_state.irqOut = state.modeIrq;
				end
			end
		end
		if (hit && bus.ioWr) begin
			// out-of-range codes are the host's fault; zero would never fire
			next_state.seconds = bus.ioWrData;
			next_state.prescale = 32'h0;
			next_state.enabled = (bus.ioWrData != 8'h00);
		end else if (hit && bus.ioRd) begin
			next_state.enabled = 1'b0;
		end
		next_state.rdData = hit && bus.ioRd ? DISABLED_READ : 8'h00;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign bus.ioRdData = state.rdData;
	assign bus.cpuReset = state.resetOut;
	assign bus.cpuIrq   = state.irqOut;
	assign running      = state.enabled;
endmodule

/* File: tb/wdt_link_props.sv */
// assertions on the watchdog i/o link
`timescale 1ns/10ps
// **
// link checker
// **
module wdt_link_props (
	input wire logic        sys_clk,
	input wire logic        rst_b,
	input wire logic [15:0] ioAddr,
	input wire logic [7:0]  ioWrData,
	input wire logic        ioWr,
	input wire logic        ioRd,
	input wire logic [7:0]  ioRdData,
	input wire logic        cpuReset,
	input wire logic        cpuIrq,
	input wire logic        running
);
	import wdt_pkg::*;
	logic fired;
	assign fired = cpuReset | cpuIrq;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	AST_ADDR: assert property (ioAddr == PORT_ADDR) else $error("addr");
	AST_CODE: assert property (ioWr |-> ioWrData inside {[CODE_MIN:CODE_MAX]})
		else $error("code");
	AST_LOAD: assert property (ioWr |=> running) else $error("start");
	AST_STOP: assert property (ioRd && !ioWr |=>
		!running && ioRdData == DISABLED_READ) else $error("stop");
	AST_FALL: assert property ($fell(running) |-> $past(ioRd) || fired)
		else $error("fall");
	AST_IDLE: assert property (!running |=> !fired) else $error("idle");
	AST_ONE: assert property (!(cpuReset && cpuIrq)) else $error("both");
	AST_PULSE: assert property (fired |=> !fired) else $error("pulse");
	cover property (ioWr ##1 running);
	cover property (ioRd ##1 !running);
	cover property (ioWr ##[1:9] ioWr);
	cover property (running ##1 fired);
endmodule

/* File: tb/io_port_watchdog_timer_tb.sv */
// bench for host and device joined over the i/o link
`timescale 1ns/10ps
// **
// bench
// **
module io_port_watchdog_timer_tb;
	import wdt_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [3:0]  regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [15:0] regRdData;
	logic        intr;
	logic        running;
	logic        want = 1'b0;
	logic        strap = 1'b0;
	// a bench second is short so that expiry fits in the run
	localparam int TICK_SHORT = 100;
	logic [15:0] rd;
	int          fail_count = 0;
	int          total_checks = 0;
	wdt_if busI ();
	wdt_host wdt_host_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .intr(intr), .bus(busI));
	wdt_device #(.TICK_LEN(TICK_SHORT)) wdt_device_i (.sys_clk(sys_clk),
		.rst_b(rst_b), .expireToIrq(strap), .bus(busI), .running(running));
	wdt_link_props wdt_link_props_i (.sys_clk(sys_clk), .rst_b(rst_b),
		.ioAddr(busI.ioAddr), .ioWrData(busI.ioWrData), .ioWr(busI.ioWr),
		.ioRd(busI.ioRd), .ioRdData(busI.ioRdData), .running(running),
		.cpuReset(busI.cpuReset), .cpuIrq(busI.cpuIrq));
	always #4 sys_clk = ~sys_clk;
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk) {regAddr, regWrData, regWr} <= {a, d, 1'b1};
		@(posedge sys_clk) regWr <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge sys_clk) {regAddr, regRd} <= {a, 1'b1};
		@(posedge sys_clk) regRd <= 1'b0;
		#1 rd = regRdData;
	endtask
	task automatic arm(input logic [7:0] c);
		logic ok;
		ok = c >= CODE_MIN && c <= CODE_MAX;
		wr(REG_CTRL, {8'h01, c});
		#1 chk(16'(busI.ioWr), 16'(ok));
		if (ok) chk(16'(busI.ioWrData), 16'(c));
		want = want | ok;
		@(posedge sys_clk) #1 chk(16'(running), 16'(want));
		rdr(REG_STATUS);
		chk(rd, {13'h0, ok, !ok, 1'b0});
	endtask
	task automatic s_codes();
		logic [7:0] codes [5] = '{8'h00, 8'h3f, CODE_MIN, 8'h02, CODE_MAX};
		foreach (codes[i]) arm(codes[i]);
		rdr(REG_DEVSTATE);
		chk(rd, 16'h0001);
	endtask
	task automatic s_stop();
		wr(REG_CTRL, 16'h0200);
		#1 chk(16'(busI.ioRd), 16'h0001);
		@(posedge sys_clk) #1 chk({busI.ioRdData, 7'h0, running}, 16'h0);
		want = 1'b0;
		rdr(REG_STATUS);
		chk(rd, 16'h0004);
		arm(CODE_MIN);
	endtask
	task automatic s_irq();
		wr(REG_MASK, 16'h0002);
		wr(REG_CTRL, 16'h0140);
		@(posedge sys_clk) #1 chk(16'(intr), 16'h0001);
		rdr(REG_STATUS);
		chk({rd[14:0], intr}, 16'h0004);
		wr(REG_MASK, 16'h0000);
		wr(REG_CTRL, 16'h0140);
		@(posedge sys_clk) #1 chk(16'(intr), 16'h0000);
		rdr(4'hf);
		chk(rd, 16'h0000);
	endtask
	// strap is only caught after a reset, so each mode gets its own
	task automatic s_expire(input logic m, input logic [7:0] c);
		int n;
		@(posedge sys_clk) {rst_b, strap} <= {1'b0, m};
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		want = 1'b0;
		@(posedge sys_clk);
		#1 chk(16'({running, intr}), 16'h0000);
		wr(REG_MASK, 16'h0001);
		wr(REG_CTRL, {8'h01, CODE_MAX});
		wr(REG_CTRL, {8'h01, c});
		n = 0;
		@(posedge sys_clk);
		#1;
		while (running === 1'b1 && n < 64 * TICK_SHORT) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		chk(16'(n), 16'(c) * 16'(TICK_SHORT));
		chk(16'({busI.cpuReset, busI.cpuIrq}), 16'({!m, m}));
		repeat (3) @(posedge sys_clk);
		#1 chk(16'(intr), 16'h0001);
		rdr(REG_STATUS);
		chk(rd, 16'h0005);
		rdr(REG_DEVSTATE);
		chk({rd[14:0], running}, 16'h0000);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_b <= 1'b1;
		s_codes();
		s_stop();
		s_irq();
		s_expire(1'b1, 8'h02);
		s_expire(1'b0, CODE_MIN);
		final_report();
	end
	// far beyond the few hundred cycles the scenarios need
	initial begin
		#100000;
		fail_count++;
		final_report();
	end
endmodule
